// ===== rtl/acr_map.vh
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// How it works
// - Codes 0..10 route pins 0..10; 11..14 temp, bandgap, supply/4, ground; 15 reserved.
// - Enable bit powers the converter; clearing it aborts a running conversion.
// - Single mode: each start write converts once; free-running: first start, then automatic.
// - First conversion after enabling takes 25 converter clocks, later ones 13.
// - Start bit reads one while converting, zero after; writing zero does nothing.
// - With auto trigger enabled and a nonzero trigger code, each rising edge of the selected trigger starts a conversion if none is running.
// - Done flag sets when a conversion finishes, whether or not the result registers are updated.
// - Done flag clears when its vector is taken or when software writes one.
// - Conversion interrupt (conv_irq) only while done flag, its enable and global enable are all set.
// - Prescaler 000/001 divide by 2, 010..111 divide by 4 up to 128.
// - Right adjust: bits 9:8 in high byte 1:0, bits 7:0 in low byte.
// - Left adjust: bits 9:2 in high byte, bits 1:0 in low byte 7:6.
// - After low byte read, result updates are blocked until high byte read.
// - Result bytes hold the latest 10-bit outcome stored while unlocked, laid out by adjust bit.
// - Channel or reference changes during a conversion apply only after it completes.
// - Selecting trigger code zero never itself produces a trigger event.
`define ACR_ADDR_CTRL_A 3'h0
`define ACR_ADDR_RES_LO 3'h1
`define ACR_ADDR_RES_HI 3'h2
`define ACR_ADDR_MUX 3'h3
`define ACR_ADDR_CTRL_B 3'h4
`define ACR_ADDR_IRQ_STAT 3'h5
`define ACR_ADDR_IRQ_CLR 3'h6
`define ACR_ADDR_IRQ_EN 3'h7
`define ACR_B_EN 7
`define ACR_B_START 6
`define ACR_B_ATE 5
`define ACR_B_DONE 4
`define ACR_B_IE 3
`define ACR_B_LAR 5
`define ACR_B_BIN 7
`define ACR_RESET_BYTE 8'h00
`define ACR_CYC_FIRST 6'h19
`define ACR_CYC_NORMAL 6'h0D
`define ACR_SEL_TEMP 4'hB
`define ACR_SEL_BANDGAP 4'hC
`define ACR_SEL_QUARTER 4'hD
`define ACR_SEL_GROUND 4'hE
`define ACR_SEL_RESERVED 4'hF
`endif

// ===== rtl/acr_ctrl.v
`timescale 1ns/10ps
`include "acr_map.vh"
module acr_ctrl (
   input wire clk_sys,
   input wire nrst,
   input wire [2:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output reg [7:0] bus_rdata,
   input wire [7:0] trigger_sources,
   input wire global_irq_enable,
   input wire irq_vector_taken,
   input wire [9:0] sample_value,
   input wire [1:0] sample_ref_unused,
   output reg conv_irq,
   output reg status_irq,
   output reg converter_power,
   output reg sample_hold,
   output reg [10:0] pin_select,
   output reg [3:0] internal_select,
   output reg diff_mode,
   output reg [3:0] diff_pos,
   output reg [3:0] diff_neg,
   output reg gain_high,
   output reg [1:0] ref_select
);
   localparam ST_IDLE = 2'd0;
   localparam ST_CONV = 2'd1;

   reg [7:0] ctrl_a_q;
   reg [7:0] mux_q;
   reg [7:0] ctrl_b_q;
   reg [9:0] result_q;
   reg lock_q;
   reg first_q;
   reg [1:0] state_q;
   reg [6:0] pre_cnt_q;
   reg [5:0] cyc_cnt_q;
   reg [5:0] cyc_len_q;
   reg [7:0] mux_live_q;
   reg [7:0] trig_s1_q;
   reg [7:0] trig_s2_q;
   reg trig_prev_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_en_q;
   reg [9:0] samp_s1_q;
   reg [9:0] samp_s2_q;

   // Division factor minus one for each prescaler code
   function [6:0] div_limit;
      input [2:0] code;
      begin
         case (code)
            3'h0: div_limit = 7'h01;
            3'h1: div_limit = 7'h01;
            3'h2: div_limit = 7'h03;
            3'h3: div_limit = 7'h07;
            3'h4: div_limit = 7'h0F;
            3'h5: div_limit = 7'h1F;
            3'h6: div_limit = 7'h3F;
            default: div_limit = 7'h7F;
         endcase
      end
   endfunction

   wire wr_a = bus_wr && (bus_addr == `ACR_ADDR_CTRL_A);
   wire en_next = wr_a ? bus_wdata[`ACR_B_EN] : ctrl_a_q[`ACR_B_EN];
   wire [2:0] tsel = ctrl_b_q[2:0];
   wire trig_now = trig_s2_q[tsel];
   // Code zero means free running, driven by completion not by an edge
   wire trig_edge = ctrl_a_q[`ACR_B_ATE] && (tsel != 3'h0) && trig_now && !trig_prev_q;
   wire start_wr = wr_a && bus_wdata[`ACR_B_START] && en_next;
   wire tick = (pre_cnt_q == div_limit(ctrl_a_q[2:0]));
   wire conv_end = (state_q == ST_CONV) && tick && (cyc_cnt_q == cyc_len_q);
   wire free_run = ctrl_a_q[`ACR_B_ATE] && (tsel == 3'h0);
   wire start_go = (start_wr || trig_edge || (conv_end && free_run)) && en_next;
   wire done_clr = irq_vector_taken || (wr_a && bus_wdata[`ACR_B_DONE]);
   wire lo_rd = bus_rd && (bus_addr == `ACR_ADDR_RES_LO);
   wire hi_rd = bus_rd && (bus_addr == `ACR_ADDR_RES_HI);
   wire [15:0] view = mux_q[`ACR_B_LAR] ? {result_q, 6'h00} : {6'h00, result_q};

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         trig_s1_q <= 8'h00;
         trig_s2_q <= 8'h00;
         samp_s1_q <= 10'h000;
         samp_s2_q <= 10'h000;
      end else begin
         trig_s1_q <= trigger_sources;
         trig_s2_q <= trig_s1_q;
         samp_s1_q <= sample_value;
         samp_s2_q <= samp_s1_q;
      end
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_a_q <= `ACR_RESET_BYTE;
         mux_q <= `ACR_RESET_BYTE;
         ctrl_b_q <= `ACR_RESET_BYTE;
         mux_live_q <= `ACR_RESET_BYTE;
         result_q <= 10'h000;
         lock_q <= 1'b0;
         first_q <= 1'b1;
         state_q <= ST_IDLE;
         pre_cnt_q <= 7'h00;
         cyc_cnt_q <= 6'h00;
         cyc_len_q <= `ACR_CYC_NORMAL;
         trig_prev_q <= 1'b0;
         irq_stat_q <= 2'b00;
         irq_en_q <= 2'b00;
      end else begin
         trig_prev_q <= trig_now;
         if (wr_a) begin
            ctrl_a_q[`ACR_B_EN] <= bus_wdata[`ACR_B_EN];
            ctrl_a_q[`ACR_B_ATE] <= bus_wdata[`ACR_B_ATE];
            ctrl_a_q[`ACR_B_IE] <= bus_wdata[`ACR_B_IE];
            ctrl_a_q[2:0] <= bus_wdata[2:0];
         end
         if (bus_wr && bus_addr == `ACR_ADDR_MUX)
            mux_q <= bus_wdata;
         if (bus_wr && bus_addr == `ACR_ADDR_CTRL_B)
            ctrl_b_q <= {1'b0, bus_wdata[6:4], 1'b0, bus_wdata[2:0]};
         if (bus_wr && bus_addr == `ACR_ADDR_IRQ_EN)
            irq_en_q <= bus_wdata[1:0];
         // Done flag: set wins over a clear in the same cycle
         if (conv_end)
            ctrl_a_q[`ACR_B_DONE] <= 1'b1;
         else if (done_clr)
            ctrl_a_q[`ACR_B_DONE] <= 1'b0;
         // Per-bit set wins, so a clear of one event never swallows the other
         if (bus_wr && bus_addr == `ACR_ADDR_IRQ_CLR)
            irq_stat_q <= (irq_stat_q & ~bus_wdata[1:0]) | {trig_edge, conv_end};
         else
            irq_stat_q <= irq_stat_q | {trig_edge, conv_end};
         if (lo_rd)
            lock_q <= 1'b1;
         else if (hi_rd)
            lock_q <= 1'b0;
         if (state_q == ST_IDLE || tick)
            pre_cnt_q <= 7'h00;
         else
            pre_cnt_q <= pre_cnt_q + 7'h01;
         if (!en_next) begin
            state_q <= ST_IDLE;
            ctrl_a_q[`ACR_B_START] <= 1'b0;
            first_q <= 1'b1;
         end else if (state_q == ST_IDLE || conv_end) begin
            if (conv_end) begin
               if (!lock_q || hi_rd)
                  result_q <= samp_s2_q;
               mux_live_q <= mux_q;
            end
            if (start_go) begin
               state_q <= ST_CONV;
               ctrl_a_q[`ACR_B_START] <= 1'b1;
               cyc_cnt_q <= 6'h01;
               cyc_len_q <= first_q ? `ACR_CYC_FIRST : `ACR_CYC_NORMAL;
               first_q <= 1'b0;
               if (state_q == ST_IDLE)
                  mux_live_q <= mux_q;
            end else if (conv_end) begin
               state_q <= ST_IDLE;
               ctrl_a_q[`ACR_B_START] <= 1'b0;
            end
         end else if (tick)
            cyc_cnt_q <= cyc_cnt_q + 6'h01;
      end
   end

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         bus_rdata <= 8'h00;
         conv_irq <= 1'b0;
         status_irq <= 1'b0;
         converter_power <= 1'b0;
         sample_hold <= 1'b0;
         pin_select <= 11'h000;
         internal_select <= 4'h0;
         diff_mode <= 1'b0;
         diff_pos <= 4'h0;
         diff_neg <= 4'h0;
         gain_high <= 1'b0;
         ref_select <= 2'b00;
      end else begin
         conv_irq <= ctrl_a_q[`ACR_B_DONE] && ctrl_a_q[`ACR_B_IE] && global_irq_enable;
         status_irq <= |(irq_stat_q & irq_en_q);
         converter_power <= ctrl_a_q[`ACR_B_EN];
         sample_hold <= (state_q == ST_CONV);
         ref_select <= mux_live_q[7:6];
         pin_select <= 11'h000;
         internal_select <= 4'h0;
         diff_pos <= 4'h0;
         diff_neg <= 4'h0;
         diff_mode <= mux_live_q[4];
         gain_high <= mux_live_q[4] & mux_live_q[0];
         if (!mux_live_q[4]) begin
            if (mux_live_q[3:0] <= 4'hA)
               pin_select <= 11'h001 << mux_live_q[3:0];
            else if (mux_live_q[3:0] != `ACR_SEL_RESERVED)
               internal_select <= mux_live_q[3:0];
         end else begin
            case (mux_live_q[3:1])
               3'h0: begin diff_pos <= 4'h0; diff_neg <= 4'h1; end
               3'h1: begin diff_pos <= 4'h1; diff_neg <= 4'h2; end
               3'h2: begin diff_pos <= 4'h2; diff_neg <= 4'h3; end
               3'h3: begin diff_pos <= 4'h4; diff_neg <= 4'h5; end
               3'h4: begin diff_pos <= 4'h5; diff_neg <= 4'h6; end
               3'h5: begin diff_pos <= 4'h6; diff_neg <= 4'h7; end
               3'h6: begin diff_pos <= 4'h8; diff_neg <= 4'h9; end
               default: begin diff_pos <= 4'h9; diff_neg <= 4'hA; end
            endcase
         end
         bus_rdata <= 8'h00;
         if (bus_rd) begin
            case (bus_addr)
               `ACR_ADDR_CTRL_A: bus_rdata <= ctrl_a_q;
               `ACR_ADDR_RES_LO: bus_rdata <= view[7:0];
               `ACR_ADDR_RES_HI: bus_rdata <= view[15:8];
               `ACR_ADDR_MUX: bus_rdata <= mux_q;
               `ACR_ADDR_CTRL_B: bus_rdata <= ctrl_b_q;
               `ACR_ADDR_IRQ_STAT: bus_rdata <= {6'h00, irq_stat_q};
               `ACR_ADDR_IRQ_EN: bus_rdata <= {6'h00, irq_en_q};
               default: bus_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // acr_ctrl

// ===== testbench/acr_ctrl_chk.sv
`timescale 1ns/10ps
module acr_chk (
   input wire clk_sys,
   input wire nrst,
   input wire [2:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire bus_wr,
   input wire global_irq_enable,
   input wire irq_vector_taken,
   input wire conv_irq,
   input wire converter_power,
   input wire sample_hold,
   input wire [10:0] pin_select,
   input wire [3:0] internal_select,
   input wire diff_mode,
   input wire [3:0] diff_pos,
   input wire [3:0] diff_neg
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   property p_irq_gate; conv_irq |-> $past(global_irq_enable); endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
   property p_vec_clr; irq_vector_taken && !sample_hold |-> ##2 !conv_irq; endproperty
   a_vec_clr: assert property (p_vec_clr) else $error("irq survives vector");
   property p_one_pin; (|pin_select) |-> $onehot(pin_select) && internal_select == 4'h0 && !diff_mode; endproperty
   a_one_pin: assert property (p_one_pin) else $error("single pin not exclusive");
   property p_pair; diff_mode |-> diff_neg == diff_pos + 4'h1 && pin_select == 11'h000; endproperty
   a_pair: assert property (p_pair) else $error("bad differential pair");
   property p_min_len; $rose(sample_hold) |=> sample_hold [*8]; endproperty
   a_min_len: assert property (p_min_len) else $error("conversion too short");
   // sample_hold rises two clocks after the start write, so the window is generous
   property p_start; bus_wr && bus_addr == 3'h0 && bus_wdata[7:6] == 2'b11 |-> ##[1:300] sample_hold; endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_off; bus_wr && bus_addr == 3'h0 && !bus_wdata[7] |-> ##[1:3] !converter_power && !sample_hold; endproperty
   a_off: assert property (p_off) else $error("disable did not abort");
   property p_hold_mux; sample_hold && $past(sample_hold) && $past(sample_hold, 2) |-> $stable(pin_select) && $stable(diff_pos); endproperty
   a_hold_mux: assert property (p_hold_mux) else $error("channel moved mid conversion");
endmodule // acr_chk
bind acr_ctrl acr_chk i_acr_chk (.clk_sys(clk_sys), .nrst(nrst), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .global_irq_enable(global_irq_enable),
   .irq_vector_taken(irq_vector_taken), .conv_irq(conv_irq), .converter_power(converter_power),
   .sample_hold(sample_hold), .pin_select(pin_select), .internal_select(internal_select),
   .diff_mode(diff_mode), .diff_pos(diff_pos), .diff_neg(diff_neg));

// ===== testbench/acr_ctrl_tb.sv
`timescale 1ns/10ps
module acr_ctrl_tb;
   reg clk_sys, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
   reg global_irq_enable = 1'b0, irq_vector_taken = 1'b0;
   reg [2:0] bus_addr = 3'h0;
   reg [7:0] bus_wdata = 8'h00, d;
   reg [9:0] sample_value = 10'h000;
   reg [7:0] trigger_sources = 8'h00;
   wire [7:0] bus_rdata;
   wire conv_irq, status_irq, converter_power, sample_hold, diff_mode, gain_high;
   wire [10:0] pin_select;
   wire [3:0] internal_select, diff_pos, diff_neg;
   wire [1:0] ref_select;
   integer mismatches = 0, samples_checked = 0, i;
   acr_ctrl i_acr_ctrl (.clk_sys(clk_sys), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .trigger_sources(trigger_sources),
      .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
      .sample_value(sample_value), .sample_ref_unused(2'h0), .conv_irq(conv_irq),
      .status_irq(status_irq), .converter_power(converter_power), .sample_hold(sample_hold),
      .pin_select(pin_select), .internal_select(internal_select), .diff_mode(diff_mode),
      .diff_pos(diff_pos), .diff_neg(diff_neg), .gain_high(gain_high), .ref_select(ref_select));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task finish_test;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input [9:0] g, input [9:0] e);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input [2:0] a, input [7:0] v);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask
   task rd(input [2:0] a);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   // Polls the start bit; each poll costs two clocks, so the count is coarse
   task conv(input integer lo, input integer hi);
      d = 8'h40;
      for (i = 0; i < 150 && d[6]; i = i + 1)
         rd(3'h0);
      if (d[6] !== 1'b0) begin
         mismatches = mismatches + 1;
         finish_test;
      end else begin
         chk(i * 2 >= lo && i * 2 <= hi, 10'h001);
         chk(d[4], 10'h001);
      end
   endtask
   task t_reset;
      for (i = 0; i < 8; i = i + 1) begin
         rd(i[2:0]);
         chk(d, 8'h00);
      end
   endtask
   task t_first;
      wr(3'h3, 8'h13);
      wr(3'h7, 8'h01);
      wr(3'h0, 8'hC8);
      sample_value <= 10'h2A5;
      conv(44, 60);
      chk(conv_irq, 10'h000);
      chk({diff_mode, gain_high, diff_pos, diff_neg}, 10'h312);
      rd(3'h1);
      chk(d, 8'hA5);
      rd(3'h2);
      chk(d, 8'h02);
      chk(status_irq, 10'h001);
      @(posedge clk_sys);
      global_irq_enable <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk(conv_irq, 10'h001);
      @(posedge clk_sys);
      irq_vector_taken <= 1'b1;
      @(posedge clk_sys);
      irq_vector_taken <= 1'b0;
      rd(3'h0);
      chk(d[4], 10'h000);
      wr(3'h6, 8'h01);
      rd(3'h5);
      chk({status_irq, d}, 10'h000);
      wr(3'h3, 8'h20);
      rd(3'h2);
      chk(d, 8'hA9);
   endtask
   task t_lock;
      wr(3'h0, 8'hD0);
      sample_value <= 10'h155;
      conv(22, 34);
      chk(pin_select, 11'h001);
      rd(3'h1);
      chk(d, 8'h40);
      wr(3'h0, 8'hD3);
      sample_value <= 10'h3FF;
      conv(98, 118);
      rd(3'h2);
      chk(d, 8'h55);
   endtask
   task t_abort;
      wr(3'h0, 8'hD0);
      repeat (10) @(posedge clk_sys);
      wr(3'h0, 8'h80);
      rd(3'h0);
      chk(d[6], 10'h001);
      wr(3'h0, 8'h00);
      rd(3'h0);
      chk({d[7:6], converter_power, sample_hold}, 10'h000);
   endtask
   task t_trig;
      wr(3'h4, 8'h02);
      wr(3'h0, 8'hA0);
      trigger_sources[2] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      conv(44, 60);
      // Free running with the done flag set must not start on its own
      wr(3'h4, 8'h00);
      repeat (4) @(posedge clk_sys);
      rd(3'h0);
      chk(d[6], 10'h000);
      trigger_sources <= 8'h00;
      sample_value <= 10'h0F0;
      wr(3'h0, 8'hF0);
      repeat (40) @(posedge clk_sys);
      rd(3'h0);
      chk({d[6], d[4]}, 10'h003);
      // Full value written back, so enable and auto trigger survive the flag clear
      wr(3'h0, 8'hB0);
      rd(3'h0);
      chk(d[4], 10'h000);
      repeat (10) @(posedge clk_sys);
      rd(3'h0);
      chk({d[6], d[4]}, 10'h003);
      rd(3'h1);
      chk(d, 8'h00);
      rd(3'h2);
      chk(d, 8'h3C);
      wr(3'h0, 8'h00);
   endtask
   task t_mux;
      wr(3'h0, 8'hC0);
      wr(3'h3, 8'h4C);
      #1 chk(pin_select, 11'h001);
      conv(44, 60);
      chk({ref_select, internal_select}, 10'h01C);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset;
      t_first;
      t_lock;
      t_abort;
      t_trig;
      t_mux;
      finish_test;
   end
endmodule // acr_ctrl_tb
